// >>> card_info_pkg.sv
// Purpose: shared constants and types of the card information register block
// Assumes: serial peripheral mode only, 25 MHz system clock
// Notes: record contents and timings beyond the fixed fields are top parameters
`default_nettype none

package card_info_pkg;

  // ****************************************
  // framing
  // ****************************************
  localparam int BYTE_BITS = 8;
  localparam logic [9:0] CMD_BYTES = 10'h006;
  localparam logic [9:0] REC_BYTES = 10'h010;
  localparam logic [9:0] OCR_BYTES = 10'h004;
  localparam logic [9:0] BLOCK_BYTES = 10'h200;
  localparam logic [9:0] CRC_BYTES = 10'h002;
  localparam logic [9:0] CSD_USER_BYTE = 10'h00e;

  // ****************************************
  // register fields and reset values
  // ****************************************
  localparam logic [31:0] OCR_VOLT_WINDOW = 32'h00ff_8000;
  localparam int OCR_BUSY_BIT = 31;
  localparam logic [15:0] RCA_RESET = 16'h0001;
  localparam logic [15:0] RCA_ALL_STANDBY = 16'h0000;
  localparam int CID_MAKER_LSB = 120;
  localparam int CID_APP_LSB = 104;
  localparam int CID_NAME_LSB = 56;
  localparam int CID_REV_LSB = 48;
  localparam int CID_SERIAL_LSB = 16;
  localparam int CID_DATE_LSB = 8;
  localparam int CID_CHECK_LSB = 1;
  localparam int CSD_USER_LSB = 8;
  localparam logic [7:0] CSD_USER_RESET = 8'h40;

  // ****************************************
  // command indexes and answer bytes
  // ****************************************
  localparam logic [5:0] CMD_GO_IDLE = 6'h00;
  localparam logic [5:0] CMD_SEND_OP = 6'h01;
  localparam logic [5:0] CMD_ASSIGN_ADDR = 6'h03;
  localparam logic [5:0] CMD_SELECT = 6'h07;
  localparam logic [5:0] CMD_READ_PARAM = 6'h09;
  localparam logic [5:0] CMD_READ_ID = 6'h0a;
  localparam logic [5:0] CMD_READ_SINGLE = 6'h11;
  localparam logic [5:0] CMD_WRITE_SINGLE = 6'h18;
  localparam logic [5:0] CMD_PROG_PARAM = 6'h1b;
  localparam logic [5:0] CMD_READ_COND = 6'h3a;
  localparam logic [7:0] R1_OK = 8'h00;
  localparam logic [7:0] R1_IDLE = 8'h01;
  localparam logic [7:0] R1_ILLEGAL = 8'h04;
  localparam logic [7:0] TOKEN_START = 8'hfe;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [7:0] DATA_ACCEPTED = 8'h05;
  localparam logic [7:0] BUSY_BYTE = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_CLK_MHZ = 25;
  localparam int POWERUP_TIME_US = 1000;
  localparam int PROG_TIME_US = 2000;
  localparam int POWERUP_CYCLES_DEF = POWERUP_TIME_US * SYS_CLK_MHZ;
  localparam int PROG_CYCLES_DEF = PROG_TIME_US * SYS_CLK_MHZ;

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_RESP, ST_WTOKEN, ST_WDATA, ST_BUSY} state_t;
  typedef enum logic [1:0] {SRC_OCR, SRC_ID, SRC_PARAM, SRC_BLOCK} src_t;
  typedef enum logic [1:0] {EV_ASSIGN, EV_SELECT, EV_PROG} event_t;

endpackage : card_info_pkg

`default_nettype wire

// >>> card_info_regs.sv
// Purpose: card information registers and serial peripheral framing
// Assumes: host drives chip select, link clock and data in
// Notes: rst stands for the power-up detector reset
//
// Overview of operation
// - link data moves in whole bytes aligned to chip select falling
// - programming finishes even when chip select is released meanwhile
// - broadcast commands are refused as illegal
// - only single-block reads and writes; multi-block commands are illegal
// - 32-bit read-only condition word, top bit shows power-up done
// - voltage bits 23..15 read one, 14..7 and reserved bits zero
// - 128-bit identity record, fixed, read-only
// - identity fields laid out by position, bit 0 always one
// - identity and condition words only sent on their read commands
// - 16-bit relative address resets to one
// - select command with address zero puts the card in standby
// - address-assign command stores the received address
// - power-up reset restores the relative address default
// - relative address is write-only, never read back
// - link offers 4-byte condition, 16-byte identity and parameter records
// - 128-bit parameter record, user byte programmable
`default_nettype none

module card_info_regs #(
  parameter int POWERUP_CYCLES = card_info_pkg::POWERUP_CYCLES_DEF,
  parameter int PROG_CYCLES = card_info_pkg::PROG_CYCLES_DEF,
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [15:0] APP_CODE = 16'h1234, // arbitrary value
  parameter logic [47:0] PRODUCT_NAME = 48'h4341_5244_3031,
  parameter logic [7:0] PRODUCT_REVISION = 8'h10,
  parameter logic [31:0] PRODUCT_SERIAL = 32'h0000_0001,
  parameter logic [7:0] MANUFACTURE_DATE = 8'h11,
  parameter logic [6:0] CID_CHECKSUM = 7'h00,
  parameter logic [127:0] CSD_FIXED = 128'h0000_0000_0000_0000_0000_0000_0000_0000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic chipSelN,
  input wire logic dataIn,
  output logic dataOut,
  output logic cardStandby,
  output logic cardBusy,
  output logic powerUpDone
);
  import card_info_pkg::*;

  logic linkRst;
  logic byteDone;
  logic [7:0] rxByte;
  logic puSync;
  logic busySync;
  state_t state_ff;
  state_t nxtState;
  src_t src_ff;
  src_t nxtSrc;
  logic [9:0] cnt_ff;
  logic [9:0] nxtCnt;
  logic [9:0] len_ff;
  logic [9:0] nxtLen;
  logic [7:0] txByte_ff;
  logic [7:0] nxtTx;
  logic [5:0] cmdIdx_ff;
  logic [31:0] arg_ff;
  logic waitBusy_ff;
  logic busyNow;
  logic fire;
  event_t nxtEvKind;
  event_t evtKind_ff;
  logic [15:0] evtArg_ff;
  logic evtToggle_ff;
  logic csdWrite;
  logic [7:0] csdUser_ff;
  logic [127:0] cidWord;
  logic [127:0] csdWord;
  logic [127:0] recSel;
  logic [127:0] recShift;
  logic [9:0] dataIdx;
  logic [7:0] dataByte;
  logic [7:0] r1;

  assign linkRst = rst | chipSelN;

  card_spi_shifter uShifter (
    .spiClk(spiClk),
    .rst(rst),
    .chipSelN(chipSelN),
    .dataIn(dataIn),
    .txByte(txByte_ff),
    .byteDone(byteDone),
    .rxByte(rxByte),
    .dataOut(dataOut)
  );

  card_sync2 #(.WIDTH(2)) uStatSync (
    .clk(spiClk),
    .rst(rst),
    .d({powerUpDone, cardBusy}),
    .q({puSync, busySync})
  );

  // ****************************************
  // record contents
  // ****************************************
  always_comb
  begin
    cidWord = '0;
    cidWord[CID_MAKER_LSB +: 8] = MAKER_CODE;
    cidWord[CID_APP_LSB +: 16] = APP_CODE;
    cidWord[CID_NAME_LSB +: 48] = PRODUCT_NAME;
    cidWord[CID_REV_LSB +: 8] = PRODUCT_REVISION;
    cidWord[CID_SERIAL_LSB +: 32] = PRODUCT_SERIAL;
    cidWord[CID_DATE_LSB +: 8] = MANUFACTURE_DATE;
    cidWord[CID_CHECK_LSB +: 7] = CID_CHECKSUM;
    cidWord[0] = 1'b1;
    csdWord = CSD_FIXED;
    csdWord[CSD_USER_LSB +: 8] = csdUser_ff;
    csdWord[0] = 1'b1;
  end

  always_comb
  begin
    unique case (src_ff)
      SRC_OCR: recSel = {OCR_VOLT_WINDOW | {puSync, 31'h0000_0000}, 96'h0};
      SRC_ID: recSel = cidWord;
      SRC_PARAM: recSel = csdWord;
      SRC_BLOCK: recSel = '0;
    endcase
    dataIdx = (src_ff == SRC_OCR) ? cnt_ff : cnt_ff - 10'h001;
    recShift = recSel << {dataIdx[3:0], 3'h0};
    dataByte = recShift[127:120];
    r1 = puSync ? R1_OK : R1_IDLE;
  end

  assign busyNow = waitBusy_ff | busySync;

  // ****************************************
  // command engine on the link clock
  // ****************************************
  always_comb
  begin
    nxtState = state_ff;
    nxtCnt = cnt_ff;
    nxtTx = txByte_ff;
    nxtSrc = src_ff;
    nxtLen = len_ff;
    nxtEvKind = EV_ASSIGN;
    fire = 1'b0;
    csdWrite = 1'b0;
    if (byteDone)
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          nxtTx = IDLE_BYTE;
          if (rxByte[7:6] == 2'b01)
          begin
            nxtState = ST_CMD;
            nxtCnt = 10'h001;
          end
        end
        ST_CMD:
        begin
          nxtCnt = cnt_ff + 10'h001;
          if (cnt_ff == CMD_BYTES - 10'h001)
          begin
            nxtCnt = 10'h000;
            nxtState = ST_IDLE;
            nxtTx = r1;
            case (cmdIdx_ff)
              CMD_GO_IDLE, CMD_SEND_OP: nxtTx = r1;
              CMD_ASSIGN_ADDR:
              begin
                fire = 1'b1;
                nxtEvKind = EV_ASSIGN;
              end
              CMD_SELECT:
              begin
                fire = 1'b1;
                nxtEvKind = EV_SELECT;
              end
              CMD_READ_COND:
              begin
                nxtState = ST_RESP;
                nxtSrc = SRC_OCR;
                nxtLen = OCR_BYTES;
              end
              CMD_READ_ID:
              begin
                nxtState = ST_RESP;
                nxtSrc = SRC_ID;
                nxtLen = REC_BYTES;
              end
              CMD_READ_PARAM:
              begin
                nxtState = ST_RESP;
                nxtSrc = SRC_PARAM;
                nxtLen = REC_BYTES;
              end
              CMD_READ_SINGLE:
              begin
                nxtState = ST_RESP;
                nxtSrc = SRC_BLOCK;
                nxtLen = BLOCK_BYTES;
              end
              CMD_WRITE_SINGLE:
              begin
                nxtState = ST_WTOKEN;
                nxtSrc = SRC_BLOCK;
                nxtLen = BLOCK_BYTES;
              end
              CMD_PROG_PARAM:
              begin
                nxtState = ST_WTOKEN;
                nxtSrc = SRC_PARAM;
                nxtLen = REC_BYTES;
              end
              default: nxtTx = R1_ILLEGAL;
            endcase
          end
        end
        ST_RESP:
        begin
          nxtCnt = cnt_ff + 10'h001;
          if (src_ff == SRC_OCR)
          begin
            if (cnt_ff < len_ff)
              nxtTx = dataByte;
            else
            begin
              nxtTx = IDLE_BYTE;
              nxtState = ST_IDLE;
            end
          end
          else if (cnt_ff == 10'h000)
            nxtTx = TOKEN_START;
          else if (cnt_ff <= len_ff)
            nxtTx = dataByte;
          else if (cnt_ff <= len_ff + CRC_BYTES)
            nxtTx = IDLE_BYTE;
          else
            nxtState = ST_IDLE;
        end
        ST_WTOKEN:
        begin
          nxtTx = IDLE_BYTE;
          if (rxByte == TOKEN_START)
          begin
            nxtState = ST_WDATA;
            nxtCnt = 10'h000;
          end
        end
        ST_WDATA:
        begin
          nxtCnt = cnt_ff + 10'h001;
          csdWrite = (src_ff == SRC_PARAM) && (cnt_ff == CSD_USER_BYTE);
          if (cnt_ff == len_ff + CRC_BYTES - 10'h001)
          begin
            nxtTx = DATA_ACCEPTED;
            nxtState = ST_BUSY;
            fire = 1'b1;
            nxtEvKind = EV_PROG;
          end
        end
        ST_BUSY:
        begin
          nxtTx = busyNow ? BUSY_BYTE : IDLE_BYTE;
          if (!busyNow)
            nxtState = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge spiClk or posedge linkRst)
  begin
    if (linkRst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 10'h000;
      src_ff <= SRC_OCR;
      len_ff <= 10'h000;
      txByte_ff <= IDLE_BYTE;
    end
    else
    begin
      state_ff <= nxtState;
      cnt_ff <= nxtCnt;
      src_ff <= nxtSrc;
      len_ff <= nxtLen;
      txByte_ff <= nxtTx;
    end
  end

  always_ff @(posedge spiClk or posedge linkRst)
  begin
    if (linkRst)
    begin
      cmdIdx_ff <= 6'h00;
      arg_ff <= 32'h0000_0000;
    end
    else if (byteDone && state_ff == ST_IDLE)
      cmdIdx_ff <= rxByte[5:0];
    else if (byteDone && state_ff == ST_CMD && cnt_ff < CMD_BYTES - 10'h001)
      arg_ff <= {arg_ff[23:0], rxByte};
  end

  always_ff @(posedge spiClk or posedge linkRst)
  begin
    if (linkRst)
      waitBusy_ff <= 1'b0;
    else if (fire && nxtEvKind == EV_PROG)
      waitBusy_ff <= 1'b1;
    else if (busySync)
      waitBusy_ff <= 1'b0;
  end

  // events and user parameter byte survive chip select release
  always_ff @(posedge spiClk or posedge rst)
  begin
    if (rst)
    begin
      evtToggle_ff <= 1'b0;
      evtKind_ff <= EV_ASSIGN;
      evtArg_ff <= 16'h0000;
    end
    else if (fire)
    begin
      evtToggle_ff <= ~evtToggle_ff;
      evtKind_ff <= nxtEvKind;
      evtArg_ff <= arg_ff[31:16];
    end
  end

  always_ff @(posedge spiClk or posedge rst)
  begin
    if (rst)
      csdUser_ff <= CSD_USER_RESET;
    else if (byteDone && csdWrite)
      csdUser_ff <= rxByte;
  end

  // ****************************************
  // system clock side
  // ****************************************
  logic evtSync;
  logic evtSeen_ff;
  logic capEvt;
  logic [15:0] rca_ff;
  logic [23:0] puCnt_ff;
  logic [23:0] progCnt_ff;

  card_sync2 #(.WIDTH(1)) uEvtSync (
    .clk(sys_clk),
    .rst(rst),
    .d(evtToggle_ff),
    .q(evtSync)
  );

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      evtSeen_ff <= 1'b0;
    else
      evtSeen_ff <= evtSync;
  end

  assign capEvt = evtSync ^ evtSeen_ff;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rca_ff <= RCA_RESET;
    else if (capEvt && evtKind_ff == EV_ASSIGN)
      rca_ff <= evtArg_ff;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cardStandby <= 1'b0;
    else if (capEvt && evtKind_ff == EV_SELECT)
      cardStandby <= (evtArg_ff == RCA_ALL_STANDBY) || (evtArg_ff != rca_ff);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      puCnt_ff <= 24'h00_0000;
      powerUpDone <= 1'b0;
    end
    else if (!powerUpDone)
    begin
      puCnt_ff <= puCnt_ff + 24'h00_0001;
      powerUpDone <= (puCnt_ff == 24'(POWERUP_CYCLES - 1));
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      progCnt_ff <= 24'h00_0000;
      cardBusy <= 1'b0;
    end
    else if (capEvt && evtKind_ff == EV_PROG)
    begin
      progCnt_ff <= 24'(PROG_CYCLES);
      cardBusy <= 1'b1;
    end
    else if (cardBusy)
    begin
      progCnt_ff <= progCnt_ff - 24'h00_0001;
      cardBusy <= (progCnt_ff > 24'h00_0001);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic assignSeen_ff;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      assignSeen_ff <= 1'b0;
    else if (capEvt && evtKind_ff == EV_ASSIGN)
      assignSeen_ff <= 1'b1;
  end

  logic decodeEdge;
  assign decodeEdge = byteDone && state_ff == ST_CMD && cnt_ff == CMD_BYTES - 10'h001;

  property p_multi_illegal;
    @(posedge spiClk) disable iff (linkRst)
    decodeEdge && cmdIdx_ff == 6'h12 |=> txByte_ff == R1_ILLEGAL && state_ff == ST_IDLE;
  endproperty
  a_multi_illegal: assert property (p_multi_illegal) else $error("multi read accepted");

  property p_bcast_illegal;
    @(posedge spiClk) disable iff (linkRst)
    decodeEdge && cmdIdx_ff == 6'h02 |=> txByte_ff == R1_ILLEGAL;
  endproperty
  a_bcast_illegal: assert property (p_bcast_illegal) else $error("broadcast accepted");

  property p_id_read;
    @(posedge spiClk) disable iff (linkRst)
    decodeEdge && cmdIdx_ff == CMD_READ_ID |=> state_ff == ST_RESP && src_ff == SRC_ID;
  endproperty
  a_id_read: assert property (p_id_read) else $error("identity read not started");

  property p_ocr_top;
    @(posedge spiClk) disable iff (linkRst)
    byteDone && state_ff == ST_RESP && src_ff == SRC_OCR && cnt_ff == 10'h000
      |=> txByte_ff[7] == $past(puSync);
  endproperty
  a_ocr_top: assert property (p_ocr_top) else $error("ready bit wrong");

  property p_ocr_window;
    @(posedge spiClk) disable iff (linkRst)
    byteDone && state_ff == ST_RESP && src_ff == SRC_OCR && cnt_ff == 10'h002
      |=> txByte_ff == 8'h80;
  endproperty
  a_ocr_window: assert property (p_ocr_window) else $error("voltage byte wrong");

  property p_cid_last;
    @(posedge spiClk) disable iff (linkRst)
    byteDone && state_ff == ST_RESP && src_ff == SRC_ID && cnt_ff == REC_BYTES
      |=> txByte_ff[0];
  endproperty
  a_cid_last: assert property (p_cid_last) else $error("identity bit 0 low");

  property p_rca_default;
    @(posedge sys_clk) disable iff (rst)
    !assignSeen_ff |-> rca_ff == 16'h0001;
  endproperty
  a_rca_default: assert property (p_rca_default) else $error("address default lost");

  property p_rca_store;
    @(posedge sys_clk) disable iff (rst)
    capEvt && evtKind_ff == EV_ASSIGN |=> rca_ff == $past(evtArg_ff);
  endproperty
  a_rca_store: assert property (p_rca_store) else $error("address not stored");

  property p_standby;
    @(posedge sys_clk) disable iff (rst)
    capEvt && evtKind_ff == EV_SELECT && evtArg_ff == 16'h0000 |=> cardStandby;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby on zero");

  property p_prog_holds;
    @(posedge sys_clk) disable iff (rst)
    cardBusy && progCnt_ff > 24'h00_0001 |=> cardBusy;
  endproperty
  a_prog_holds: assert property (p_prog_holds) else $error("programming cut short");

  c_ocr_read: cover property (@(posedge spiClk) decodeEdge && cmdIdx_ff == CMD_READ_COND);
  c_block_write: cover property (@(posedge sys_clk) capEvt && evtKind_ff == EV_PROG);
  c_busy_desel: cover property (@(posedge sys_clk) cardBusy && chipSelN);

endmodule : card_info_regs

`default_nettype wire

// >>> card_spi_shifter.sv
// Purpose: byte framing of the serial link on the link clock
// Assumes: link clock only toggles while chip select is low
// Notes: data out changes on the falling edge, sampled by the host on rising
`default_nettype none

module card_spi_shifter (
  input wire logic spiClk,
  input wire logic rst,
  input wire logic chipSelN,
  input wire logic dataIn,
  input wire logic [card_info_pkg::BYTE_BITS-1:0] txByte,
  output logic byteDone,
  output logic [card_info_pkg::BYTE_BITS-1:0] rxByte,
  output logic dataOut
);
  import card_info_pkg::*;

  logic linkRst;
  logic [2:0] bitCnt_ff;
  logic [6:0] shift_ff;

  assign linkRst = rst | chipSelN;

  // ****************************************
  // bit counter aligned to chip select
  // ****************************************
  always_ff @(posedge spiClk or posedge linkRst)
  begin
    if (linkRst)
      bitCnt_ff <= 3'h0;
    else
      bitCnt_ff <= bitCnt_ff + 3'h1;
  end

  always_ff @(posedge spiClk or posedge linkRst)
  begin
    if (linkRst)
      shift_ff <= 7'h00;
    else
      shift_ff <= {shift_ff[5:0], dataIn};
  end

  assign byteDone = (bitCnt_ff == 3'h7);
  assign rxByte = {shift_ff, dataIn};

  always_ff @(negedge spiClk or posedge linkRst)
  begin
    if (linkRst)
      dataOut <= 1'b1;
    else
      dataOut <= txByte[3'h7 - bitCnt_ff];
  end

  // ****************************************
  // checks
  // ****************************************
  property p_byte_frame;
    @(posedge spiClk) disable iff (linkRst)
    byteDone |=> (!byteDone)[*7] ##1 byteDone;
  endproperty
  a_byte_frame: assert property (p_byte_frame) else $error("byte not 8 bits");

endmodule : card_spi_shifter

`default_nettype wire

// >>> card_sync2.sv
// Purpose: two-flop level synchroniser
// Assumes: input levels held for several destination cycles
// Notes: first stage feeds only the second
`default_nettype none

module card_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      q <= '0;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule : card_sync2

`default_nettype wire

// >>> host_link_model.sv
// Purpose: host end of the serial card link
// Assumes: link clock idles low and runs only inside a frame
// Notes: 6 ns link clock; data taken by the host on the rising edge
`default_nettype none

module host_link_model (
  output logic spiClk,
  output logic chipSelN,
  output logic dataIn,
  input wire logic dataOut
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    spiClk = 1'b0;
    chipSelN = 1'b1;
    dataIn = 1'b1;
  end

  // open or close a frame, held low for the whole transaction
  task automatic frame(input logic on);
    #5 chipSelN = !on;
    dataIn = 1'b1;
    #5;
  endtask : frame

  // one whole byte, msb first, aligned to the select edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      dataIn = tx[i];
      #3 spiClk = 1'b1;
      rx[i] = dataOut;
      #3 spiClk = 1'b0;
    end
  endtask : xfer
endmodule : host_link_model

`default_nettype wire

// >>> test_card_info_regs.sv
// Purpose: self-checking bench of the card information register block
// Assumes: short power-up and programming counts
// Notes: link driven by the host model
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module test_card_info_regs;
  import card_info_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [5:0] idx; logic [31:0] arg; logic [7:0] r1; logic sb;} row_t;
  logic sys_clk;
  logic rst;
  logic spiClk;
  logic chipSelN;
  logic dataIn;
  logic dataOut;
  logic cardStandby;
  logic cardBusy;
  logic powerUpDone;
  logic [7:0] q[18];
  logic [7:0] rb;
  int checks = 0;
  int n_mismatch = 0;
  localparam logic [143:0] ID_EXP = {R1_OK, TOKEN_START, 8'h5a, 8'h12, 8'h34, 8'h43, 8'h41,
    8'h52, 8'h44, 8'h30, 8'h31, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h11, 8'h01};
  row_t rows[9] = '{
    '{CMD_READ_COND, 32'h0000_0000, R1_OK, 1'b0},
    '{6'h12, 32'h0000_0000, R1_ILLEGAL, 1'b0},
    '{6'h19, 32'h0000_0000, R1_ILLEGAL, 1'b0},
    '{6'h02, 32'h0000_0000, R1_ILLEGAL, 1'b0},
    '{CMD_ASSIGN_ADDR, 32'h1234_0000, R1_OK, 1'b0},
    '{CMD_SELECT, 32'h1234_0000, R1_OK, 1'b0},
    '{CMD_SELECT, 32'h0000_0000, R1_OK, 1'b1},
    '{CMD_GO_IDLE, 32'h0000_0000, R1_OK, 1'b1},
    '{CMD_READ_SINGLE, 32'h0000_0000, R1_OK, 1'b1}};

  always #20 sys_clk = ~sys_clk;

  card_info_regs #(.POWERUP_CYCLES(20), .PROG_CYCLES(10)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .spiClk(spiClk), .chipSelN(chipSelN), .dataIn(dataIn), .dataOut(dataOut),
    .cardStandby(cardStandby), .cardBusy(cardBusy), .powerUpDone(powerUpDone));

  host_link_model host_u (.spiClk(spiClk), .chipSelN(chipSelN), .dataIn(dataIn),
    .dataOut(dataOut));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // command frame left open, n answer bytes collected
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input int n);
    logic [47:0] f;
    f = {2'b01, idx, arg, 8'h95};
    host_u.frame(1'b1);
    for (int i = 5; i >= 0; i--)
      host_u.xfer(f[i*8 +: 8], rb);
    for (int i = 0; i < n; i++)
    begin
      host_u.xfer(IDLE_BYTE, rb);
      q[i] = rb;
    end
  endtask : cmd

  // expected bytes packed first byte highest, n of them
  task automatic expect_q(input string nm, input logic [143:0] e, input int n);
    for (int i = 0; i < n; i++)
      `CHK(nm, e[(n-1-i)*8 +: 8], q[i])
  endtask : expect_q

  task automatic run_row(input row_t r);
    cmd(r.idx, r.arg, 1);
    host_u.frame(1'b0);
    repeat (6) @(negedge sys_clk);
    `CHK("answer", r.r1, q[0])
    `CHK("standby", r.sb, cardStandby)
  endtask : run_row

  task automatic wait_lvl(input logic busy, input logic v, input int lim);
    int k;
    k = 0;
    while (((busy ? cardBusy : powerUpDone) !== v) && k < lim)
    begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= lim)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask : wait_lvl

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    cmd(CMD_READ_COND, 32'h0000_0000, 2);
    host_u.frame(1'b0);
    expect_q("early cond", {R1_IDLE, 8'h00}, 2);
    `CHK("pu early", 1'b0, powerUpDone)
    wait_lvl(1'b0, 1'b1, 100);
    foreach (rows[i])
      run_row(rows[i]);
    cmd(CMD_READ_COND, 32'h0000_0000, 6);
    host_u.frame(1'b0);
    expect_q("cond", {R1_OK, 8'h80, 8'hff, 8'h80, 8'h00, IDLE_BYTE}, 6);
    cmd(CMD_READ_ID, 32'h0000_0000, 18);
    host_u.frame(1'b0);
    expect_q("ident", ID_EXP, 18);
    cmd(CMD_READ_PARAM, 32'h0000_0000, 18);
    host_u.frame(1'b0);
    `CHK("param user", CSD_USER_RESET, q[16])
    `CHK("param last", 8'h01, q[17])
    @(posedge sys_clk) rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    `CHK("standby reset", 1'b0, cardStandby)
    repeat (20) @(negedge sys_clk);
    `CHK("pu pending", 1'b0, powerUpDone)
    @(negedge sys_clk);
    `CHK("pu done", 1'b1, powerUpDone)
    wait_lvl(1'b0, 1'b1, 100);
    run_row('{CMD_SELECT, 32'h1234_0000, R1_OK, 1'b1});
    run_row('{CMD_SELECT, 32'h0001_0000, R1_OK, 1'b0});
    cmd(CMD_WRITE_SINGLE, 32'h0000_0000, 1);
    `CHK("write answer", R1_OK, q[0])
    host_u.xfer(TOKEN_START, rb);
    repeat (514) host_u.xfer(8'h00, rb);
    host_u.xfer(IDLE_BYTE, rb);
    `CHK("accepted", DATA_ACCEPTED, rb)
    host_u.xfer(IDLE_BYTE, rb);
    `CHK("busy byte", BUSY_BYTE, rb)
    host_u.frame(1'b0);
    wait_lvl(1'b1, 1'b1, 20);
    repeat (2) @(negedge sys_clk);
    `CHK("busy deselected", 1'b1, cardBusy)
    wait_lvl(1'b1, 1'b0, 40);
    cmd(CMD_PROG_PARAM, 32'h0000_0000, 1);
    `CHK("prog answer", R1_OK, q[0])
    host_u.xfer(TOKEN_START, rb);
    for (int i = 0; i < 18; i++)
      host_u.xfer((i == 14) ? 8'h5c : 8'h00, rb);
    host_u.xfer(IDLE_BYTE, rb);
    `CHK("prog accepted", DATA_ACCEPTED, rb)
    host_u.frame(1'b0);
    wait_lvl(1'b1, 1'b1, 20);
    wait_lvl(1'b1, 1'b0, 40);
    cmd(CMD_READ_PARAM, 32'h0000_0000, 18);
    host_u.frame(1'b0);
    `CHK("param written", 8'h5c, q[16])
    complete_run();
  end
endmodule : test_card_info_regs

`default_nettype wire
